// File: hdl/fls_pkg.sv
// Shared constants and types for the floating-point load/store address unit
package fls_pkg;

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int XLEN = 64;
  localparam int DISP_W = 16;
  localparam int REG_IDX_W = 5;
  localparam int WORD_W = 32;
  localparam logic [REG_IDX_W-1:0] REG_ZERO = 5'h00;

  // ----------------------------------------------------------------
  // Format conversion constants (exponent fields and fraction widths)
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_EXP_MAX = 8'hFF;
  localparam logic [10:0] DP_EXP_MAX = 11'h7FF;
  localparam logic [10:0] EXP_REBIAS = 11'h380;   // 1023 - 127
  localparam logic [10:0] DP_NORM_LIM = 11'h380;  // Above this a store stays normal
  localparam logic [10:0] DP_DENORM_LO = 11'h36A; // Lowest exponent still denormalised
  localparam logic [10:0] DP_DENORM_REF = 11'h39E; // Shift reference for denormalising
  localparam logic [10:0] SP_DENORM_REF = 11'h381; // Exponent base for denormal loads
  localparam int SP_FRAC_W = 23;
  localparam int DP_FRAC_W = 52;
  localparam int FRAC_PAD_W = 29;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_ILL_CNT = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_EA_LO = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_EA_HI = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILL_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ILL_CNT_W = 16;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_MEM
  } fls_state_t;

endpackage

// File: hdl/fls_fp_cvt.sv
// Single/double precision format conversion for loads and stores
`timescale 1ns/1ns
`default_nettype none

module fls_fp_cvt (
  // Load path: memory word to register image
  input wire logic [31:0] i_sp_word,
  output logic [63:0] o_dp_val,
  // Store path: register image to memory word
  input wire logic [63:0] i_dp_val,
  output logic [31:0] o_sp_word
);

  logic sgn_l;
  logic [7:0] exp_l;
  logic [22:0] frac_l;
  logic [4:0] msb_l;
  logic [4:0] shl_l;
  logic [22:0] norm_l;
  logic [10:0] dexp_l;
  logic [10:0] exp_s;
  logic [10:0] shr_s;
  logic [52:0] mant_s;
  logic [52:0] den_s;

  // ----------------------------------------------------------------
  // Single to double widening
  // ----------------------------------------------------------------
  always_comb begin
    sgn_l = i_sp_word[31];
    exp_l = i_sp_word[30:23];
    frac_l = i_sp_word[22:0];
    msb_l = 5'h00;
    for (int i = 0; i < fls_pkg::SP_FRAC_W; i++) begin
      if (frac_l[i]) begin
        msb_l = 5'(i);
      end
    end
    shl_l = 5'(fls_pkg::SP_FRAC_W) - msb_l;
    norm_l = frac_l << shl_l;
    dexp_l = fls_pkg::SP_DENORM_REF - {6'h00, shl_l};
    if (exp_l == fls_pkg::SP_EXP_MAX) begin
      o_dp_val = {sgn_l, fls_pkg::DP_EXP_MAX, frac_l, 29'h0000_0000};
    end else if (exp_l != 8'h00) begin
      o_dp_val = {sgn_l, {3'h0, exp_l} + fls_pkg::EXP_REBIAS, frac_l, 29'h0000_0000};
    end else if (frac_l == 23'h00_0000) begin
      o_dp_val = {sgn_l, 63'h0000_0000_0000_0000};
    end else begin
      o_dp_val = {sgn_l, dexp_l, norm_l, 29'h0000_0000}; // Denormal input renormalised
    end
  end

  // ----------------------------------------------------------------
  // Double to single narrowing; exponent alone decides, no enable bit
  // ----------------------------------------------------------------
  always_comb begin
    exp_s = i_dp_val[62:52];
    mant_s = {1'b1, i_dp_val[51:0]};
    shr_s = fls_pkg::DP_DENORM_REF - exp_s;
    den_s = mant_s >> shr_s;
    if (exp_s <= fls_pkg::DP_NORM_LIM && exp_s >= fls_pkg::DP_DENORM_LO) begin
      o_sp_word = {i_dp_val[63], 8'h00, den_s[22:0]};
    end else begin
      o_sp_word = {i_dp_val[63:62], i_dp_val[58:29]};
    end
  end

endmodule

`default_nettype wire

// File: hdl/fls_top.sv
// Floating-point load/store address, data and writeback unit with APB status
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Immediate form: sign-extended displacement plus base
// - Base field zero means zero base
// - Indexed form: base operand plus index register
// - Update form with zero base is invalid
// - Condition record bit set is invalid
// - Underflow enable never steers store denormalisation
// - Single load widened to double into target
// - Double load copied unchanged into target
// - Update forms write address back to base
// - Single store narrowed from double to word
// - Double store written unchanged to memory
// - Integer word store writes low 32 bits
module fls_top (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Issue side
  input wire logic I_ISSUE_VALID,
  output logic O_ISSUE_READY,
  input wire logic I_IS_STORE,
  input wire logic I_IS_DOUBLE,
  input wire logic I_IS_INDEXED,
  input wire logic I_IS_UPDATE,
  input wire logic I_IS_INT_WORD,
  input wire logic I_COND_RECORD_BIT,
  input wire logic [4:0] I_BASE_REG_FIELD,
  input wire logic [4:0] I_FP_REG,
  input wire logic [15:0] I_DISPLACEMENT,
  input wire logic [63:0] I_BASE_VAL,
  input wire logic [63:0] I_INDEX_VAL,
  input wire logic [63:0] I_FP_SOURCE_VAL,
  // Exception side
  output logic O_ILLEGAL,
  // Memory access path
  output logic O_MEM_REQ,
  output logic O_MEM_WE,
  output logic O_MEM_DWORD,
  output logic [63:0] O_MEM_ADDR,
  output logic [63:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [63:0] I_MEM_RDATA,
  // Floating-point register write port
  output logic O_FPR_WE,
  output logic [4:0] O_FPR_WADDR,
  output logic [63:0] O_FPR_WDATA,
  // General register write port
  output logic O_GPR_WE,
  output logic [4:0] O_GPR_WADDR,
  output logic [63:0] O_GPR_WDATA,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);

  fls_pkg::fls_state_t state_ff;
  fls_pkg::fls_state_t nxt_state;
  logic ready_ff;
  logic ctrl_en_ff;
  logic nxt_ctrl_en;
  logic ill_seen_ff;
  logic [fls_pkg::ILL_CNT_W-1:0] ill_cnt_ff;
  logic ill_ff;
  logic req_ff;
  logic we_ff;
  logic dword_ff;
  logic [63:0] addr_ff;
  logic [63:0] wdata_ff;
  logic int_ff;
  logic upd_ff;
  logic [4:0] fpr_ff;
  logic [4:0] base_ff;
  logic fpr_we_ff;
  logic [63:0] fpr_wdata_ff;
  logic gpr_we_ff;
  logic [63:0] gpr_wdata_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic accept;
  logic invalid;
  logic [63:0] base_op;
  logic [63:0] offset;
  logic [63:0] eff_addr;
  logic [63:0] store_data;
  logic [63:0] load_dp;
  logic [31:0] store_sp;
  logic apb_setup;
  logic apb_wr;
  logic ill_clr;

  // ----------------------------------------------------------------
  // Register decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == fls_pkg::ADDR_CTRL) || (a == fls_pkg::ADDR_STATUS) ||
               (a == fls_pkg::ADDR_ILL_CNT) || (a == fls_pkg::ADDR_EA_LO) ||
               (a == fls_pkg::ADDR_EA_HI);
  endfunction

  function automatic logic [31:0] bit_at(input int pos, input logic v);
    bit_at = 32'h0000_0000;
    bit_at[pos] = v;
  endfunction

  // ----------------------------------------------------------------
  // Effective address formation
  // ----------------------------------------------------------------
  always_comb begin
    if (I_BASE_REG_FIELD == fls_pkg::REG_ZERO && !I_IS_UPDATE) begin
      base_op = 64'h0000_0000_0000_0000;
    end else begin
      base_op = I_BASE_VAL;
    end
    if (I_IS_INDEXED) begin
      offset = I_INDEX_VAL;
    end else begin
      offset = {{(fls_pkg::XLEN - fls_pkg::DISP_W){I_DISPLACEMENT[15]}}, I_DISPLACEMENT};
    end
    eff_addr = base_op + offset;
  end

  // Invalid form detection; integer word store exists only as plain indexed
  assign invalid = (I_IS_UPDATE && I_BASE_REG_FIELD == fls_pkg::REG_ZERO) ||
                   I_COND_RECORD_BIT ||
                   (I_IS_INT_WORD && !(I_IS_STORE && I_IS_INDEXED && !I_IS_UPDATE));

  assign accept = ready_ff && I_ISSUE_VALID;

  // ----------------------------------------------------------------
  // Format conversion
  // ----------------------------------------------------------------
  fls_fp_cvt u_cvt (
    .i_sp_word(I_MEM_RDATA[31:0]),
    .o_dp_val(load_dp),
    .i_dp_val(I_FP_SOURCE_VAL),
    .o_sp_word(store_sp)
  );

  // Store data selection by access kind
  always_comb begin
    if (I_IS_INT_WORD) begin
      store_data = {32'h0000_0000, I_FP_SOURCE_VAL[31:0]};
    end else if (I_IS_DOUBLE) begin
      store_data = I_FP_SOURCE_VAL;
    end else begin
      store_data = {32'h0000_0000, store_sp};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fls_pkg::ST_IDLE: begin
        if (accept && !invalid) begin
          nxt_state = fls_pkg::ST_MEM;
        end
      end
      fls_pkg::ST_MEM: begin
        if (I_MEM_ACK) begin
          nxt_state = fls_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State and issue readiness; ready only while idle and enabled
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff <= fls_pkg::ST_IDLE;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == fls_pkg::ST_IDLE) && nxt_ctrl_en && !accept;
    end
  end

  // Memory request; held until acknowledged, never issued for invalid forms
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      dword_ff <= 1'b0;
      addr_ff <= 64'h0000_0000_0000_0000;
      wdata_ff <= 64'h0000_0000_0000_0000;
      int_ff <= 1'b0;
      upd_ff <= 1'b0;
      fpr_ff <= 5'h00;
      base_ff <= 5'h00;
    end else if (accept && !invalid) begin
      req_ff <= 1'b1;
      we_ff <= I_IS_STORE;
      dword_ff <= I_IS_DOUBLE && !I_IS_INT_WORD;
      addr_ff <= eff_addr;
      wdata_ff <= I_IS_STORE ? store_data : 64'h0000_0000_0000_0000;
      int_ff <= I_IS_INT_WORD;
      upd_ff <= I_IS_UPDATE;
      fpr_ff <= I_FP_REG;
      base_ff <= I_BASE_REG_FIELD;
    end else if (req_ff && I_MEM_ACK) begin
      req_ff <= 1'b0;
    end
  end

  // Register writebacks, one-cycle pulses after the acknowledge
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fpr_we_ff <= 1'b0;
      fpr_wdata_ff <= 64'h0000_0000_0000_0000;
      gpr_we_ff <= 1'b0;
      gpr_wdata_ff <= 64'h0000_0000_0000_0000;
    end else begin
      fpr_we_ff <= req_ff && I_MEM_ACK && !we_ff;
      gpr_we_ff <= req_ff && I_MEM_ACK && upd_ff;
      if (req_ff && I_MEM_ACK && !we_ff) begin
        fpr_wdata_ff <= dword_ff ? I_MEM_RDATA : load_dp;
      end
      if (req_ff && I_MEM_ACK && upd_ff) begin
        gpr_wdata_ff <= addr_ff;
      end
    end
  end

  // Illegal-instruction pulse toward exception logic
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ill_ff <= 1'b0;
    end else begin
      ill_ff <= accept && invalid;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, read data captured at setup, write data taken in the access phase
  // ----------------------------------------------------------------
  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_wr = I_PSEL && I_PENABLE && pready_ff && I_PWRITE;
  assign ill_clr = apb_wr && I_PADDR == fls_pkg::ADDR_STATUS && I_PWDATA[fls_pkg::STAT_ILL_BIT];

  always_comb begin
    nxt_ctrl_en = ctrl_en_ff;
    if (apb_wr && I_PADDR == fls_pkg::ADDR_CTRL) begin
      nxt_ctrl_en = I_PWDATA[fls_pkg::CTRL_EN_BIT];
    end
  end

  // Control register
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_en_ff <= fls_pkg::CTRL_EN_RST;
    end else begin
      ctrl_en_ff <= nxt_ctrl_en;
    end
  end

  // Sticky illegal flag, a new event wins over a clear; wrapping counter
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ill_seen_ff <= 1'b0;
      ill_cnt_ff <= 16'h0000;
    end else begin
      if (accept && invalid) begin
        ill_seen_ff <= 1'b1;
        ill_cnt_ff <= ill_cnt_ff + 16'h0001;
      end else if (ill_clr) begin
        ill_seen_ff <= 1'b0;
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !addr_hit(I_PADDR);
      if (apb_setup && !I_PWRITE) begin
        unique case (I_PADDR)
          fls_pkg::ADDR_CTRL: prdata_ff <= bit_at(fls_pkg::CTRL_EN_BIT, ctrl_en_ff);
          fls_pkg::ADDR_STATUS: prdata_ff <= bit_at(fls_pkg::STAT_BUSY_BIT, req_ff) |
                                             bit_at(fls_pkg::STAT_ILL_BIT, ill_seen_ff);
          fls_pkg::ADDR_ILL_CNT: prdata_ff <= {16'h0000, ill_cnt_ff};
          fls_pkg::ADDR_EA_LO: prdata_ff <= addr_ff[31:0];
          fls_pkg::ADDR_EA_HI: prdata_ff <= addr_ff[63:32];
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive, all from flip-flops
  // ----------------------------------------------------------------
  assign O_ISSUE_READY = ready_ff;
  assign O_ILLEGAL = ill_ff;
  assign O_MEM_REQ = req_ff;
  assign O_MEM_WE = we_ff;
  assign O_MEM_DWORD = dword_ff;
  assign O_MEM_ADDR = addr_ff;
  assign O_MEM_WDATA = wdata_ff;
  assign O_FPR_WE = fpr_we_ff;
  assign O_FPR_WADDR = fpr_ff;
  assign O_FPR_WDATA = fpr_wdata_ff;
  assign O_GPR_WE = gpr_we_ff;
  assign O_GPR_WADDR = base_ff;
  assign O_GPR_WDATA = gpr_wdata_ff;
  assign O_PRDATA = prdata_ff;
  assign O_PREADY = pready_ff;
  assign O_PSLVERR = pslverr_ff;

endmodule

`default_nettype wire

// File: verification/fls_top_sva.sv
// Concurrent checks on the ports of the load/store address unit
`timescale 1ns/1ns
`default_nettype none

module fls_top_sva (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Issue side
  input wire logic I_ISSUE_VALID,
  input wire logic O_ISSUE_READY,
  input wire logic I_IS_STORE,
  input wire logic I_IS_INDEXED,
  input wire logic I_IS_UPDATE,
  input wire logic I_IS_INT_WORD,
  input wire logic I_COND_RECORD_BIT,
  input wire logic [4:0] I_BASE_REG_FIELD,
  input wire logic [15:0] I_DISPLACEMENT,
  input wire logic [63:0] I_BASE_VAL,
  input wire logic [63:0] I_INDEX_VAL,
  // Results
  input wire logic O_ILLEGAL,
  input wire logic O_MEM_REQ,
  input wire logic O_MEM_WE,
  input wire logic O_MEM_DWORD,
  input wire logic [63:0] O_MEM_ADDR,
  input wire logic [63:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [63:0] I_MEM_RDATA,
  input wire logic O_FPR_WE,
  input wire logic [63:0] O_FPR_WDATA,
  input wire logic O_GPR_WE,
  input wire logic [63:0] O_GPR_WDATA
);
  logic acc;
  logic bad;
  logic zf;
  logic [63:0] sx;
  logic [63:0] ea;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  // Accept, invalid form and reference address
  assign acc = I_ISSUE_VALID && O_ISSUE_READY;
  assign zf = I_BASE_REG_FIELD == 5'h00;
  assign bad = I_COND_RECORD_BIT || (I_IS_UPDATE && zf) ||
               (I_IS_INT_WORD && (!I_IS_STORE || !I_IS_INDEXED || I_IS_UPDATE));
  assign sx = {{48{I_DISPLACEMENT[15]}}, I_DISPLACEMENT};
  assign ea = ((zf && !I_IS_UPDATE) ? 64'h0 : I_BASE_VAL) + (I_IS_INDEXED ? I_INDEX_VAL : sx);

  chk_cr_invalid: assert property (acc && I_COND_RECORD_BIT |=> O_ILLEGAL)
    else $error("record bit form not flagged");
  chk_upd_zero: assert property (acc && I_IS_UPDATE && zf |=> O_ILLEGAL)
    else $error("update form with zero base not flagged");
  chk_ill_quiet: assert property (O_ILLEGAL |->
    (!O_MEM_REQ && !O_FPR_WE && !O_GPR_WE) ##1 !O_ILLEGAL)
    else $error("invalid form had effects");
  chk_imm_addr: assert property (acc && !bad && !I_IS_INDEXED |=>
    O_MEM_REQ && O_MEM_ADDR == $past(ea))
    else $error("immediate address wrong");
  chk_zero_base: assert property (acc && !bad && zf |=>
    O_MEM_ADDR == $past(I_IS_INDEXED ? I_INDEX_VAL : sx))
    else $error("zero base not used as zero");
  chk_idx_addr: assert property (acc && !bad && I_IS_INDEXED |=>
    O_MEM_REQ && O_MEM_ADDR == $past(ea))
    else $error("indexed address wrong");
  chk_upd_back: assert property (O_GPR_WE |->
    O_GPR_WDATA == O_MEM_ADDR && $past(O_MEM_REQ) && !O_MEM_REQ)
    else $error("address write back wrong");
  chk_dload_copy: assert property (I_MEM_ACK && O_MEM_REQ && !O_MEM_WE && O_MEM_DWORD |=>
    O_FPR_WE && O_FPR_WDATA == $past(I_MEM_RDATA))
    else $error("double load not copied");
  chk_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK |=>
    O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA))
    else $error("memory request not held");
endmodule

`default_nettype wire

// File: verification/fls_mem_model.sv
// Memory access path model: acks a request after a set wait
`timescale 1ns/1ns
`default_nettype none

module fls_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request side
  input wire logic i_req,
  input wire logic [3:0] i_wait,
  input wire logic [63:0] i_data,
  // Answer side
  output logic o_ack,
  output logic [63:0] o_rdata
);
  logic [3:0] cnt_ff;
  logic ack_ff;

  // One ack pulse per request, rising i_wait + 1 cycles after the request appears
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (ack_ff || !i_req) begin
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (cnt_ff == i_wait) begin
      ack_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Read data only meaningful with ack, scrambled otherwise
  assign o_ack = ack_ff;
  assign o_rdata = ack_ff ? i_data : ~i_data;
endmodule

`default_nettype wire

// File: verification/fls_top_tb.sv
// Self-checking testbench for the load/store address unit
`timescale 1ns/1ns
`default_nettype none

module fls_top_tb;
  logic clk, rst_n, v, st, dbl, idx, upd, iw, cr, psel, pen, pwr;
  logic o_rdy, o_ill, o_req, o_we, o_dw, ack, o_fwe, o_gwe, o_rdyp, o_err;
  logic [4:0] bfld, fpr, o_fa, o_ga;
  logic [15:0] disp;
  logic [63:0] bv, iv, fv, o_addr, o_wd, rdata, mdata, o_fd, o_gd;
  logic [7:0] paddr;
  logic [31:0] pwdata, o_prdata, rd;
  logic [3:0] mwait;
  logic er;
  int err_count, comparisons;

  fls_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ISSUE_VALID(v), .O_ISSUE_READY(o_rdy),
    .I_IS_STORE(st), .I_IS_DOUBLE(dbl), .I_IS_INDEXED(idx), .I_IS_UPDATE(upd),
    .I_IS_INT_WORD(iw), .I_COND_RECORD_BIT(cr), .I_BASE_REG_FIELD(bfld), .I_FP_REG(fpr),
    .I_DISPLACEMENT(disp), .I_BASE_VAL(bv), .I_INDEX_VAL(iv), .I_FP_SOURCE_VAL(fv),
    .O_ILLEGAL(o_ill), .O_MEM_REQ(o_req), .O_MEM_WE(o_we), .O_MEM_DWORD(o_dw),
    .O_MEM_ADDR(o_addr), .O_MEM_WDATA(o_wd), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata),
    .O_FPR_WE(o_fwe), .O_FPR_WADDR(o_fa), .O_FPR_WDATA(o_fd), .O_GPR_WE(o_gwe),
    .O_GPR_WADDR(o_ga), .O_GPR_WDATA(o_gd), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(o_prdata), .O_PREADY(o_rdyp),
    .O_PSLVERR(o_err));

  fls_mem_model u_mem (.i_clk(clk), .i_rst_n(rst_n), .i_req(o_req), .i_wait(mwait),
    .i_data(mdata), .o_ack(ack), .o_rdata(rdata));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic lim(input int n);
    if (n >= 50) begin
      err_count++;
      finish_test();
    end
  endtask

  // APB transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (o_rdyp !== 1'b1 && n < 50);
    rd = o_prdata;
    er = o_err;
    psel <= 1'b0;
    pen <= 1'b0;
    lim(n);
  endtask

  // Issue one operation; returns 1 ns after the accept edge
  task automatic issue(input logic [5:0] f, input logic [4:0] b, input logic [15:0] d,
      input logic [63:0] b_v, input logic [63:0] i_v, input logic [63:0] f_v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (o_rdy !== 1'b1 && n < 50);
    lim(n);
    {st, dbl, idx, upd, iw, cr} <= f;
    bfld <= b;
    fpr <= 5'h07;
    disp <= d;
    bv <= b_v;
    iv <= i_v;
    fv <= f_v;
    v <= 1'b1;
    @(posedge clk);
    v <= 1'b0;
    #1;
  endtask

  // Check the memory request, then wait until it completes
  task automatic mem(input logic w, input logic dw, input logic [63:0] a, input logic [63:0] wd);
    int n;
    chk(o_req, 1'b1);
    chk(o_we, w);
    chk(o_dw, dw);
    chk(o_addr, a);
    if (w) chk(o_wd, wd);
    n = 0;
    while (o_req !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    lim(n);
  endtask

  task automatic s_regs();
    apb(1'b0, fls_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    apb(1'b1, fls_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(o_rdy, 1'b0);
    apb(1'b1, fls_pkg::ADDR_CTRL, 32'h0000_0001);
  endtask

  task automatic s_loads();
    mdata <= 64'h0123_4567_89AB_CDEF;
    issue(6'b010000, 5'h03, 16'hFFF0, 64'h1000, 64'h0, 64'h0);
    mem(1'b0, 1'b1, 64'h0FF0, 64'h0);
    chk({o_fwe, o_fa, o_gwe}, 7'b1_00111_0);
    chk(o_fd, 64'h0123_4567_89AB_CDEF);
    mwait <= 4'h3;
    mdata <= 64'h0000_0000_3F80_0000;
    issue(6'b001000, 5'h00, 16'h0, 64'h5555_0000, 64'h2000, 64'h0);
    mem(1'b0, 1'b0, 64'h2000, 64'h0);
    chk(o_fd, 64'h3FF0_0000_0000_0000);
  endtask

  task automatic s_stores();
    mwait <= 4'h1;
    issue(6'b110100, 5'h05, 16'h0008, 64'h100, 64'h0, 64'hC000_0000_0000_0001);
    mem(1'b1, 1'b1, 64'h108, 64'hC000_0000_0000_0001);
    chk({o_gwe, o_ga}, 6'b1_00101);
    chk(o_gd, 64'h108);
    issue(6'b100000, 5'h01, 16'h0, 64'h40, 64'h0, 64'h3FF0_0000_0000_0000);
    mem(1'b1, 1'b0, 64'h40, 64'h3F80_0000);
    issue(6'b100000, 5'h01, 16'h0004, 64'h40, 64'h0, 64'h37F0_0000_0000_0000);
    mem(1'b1, 1'b0, 64'h44, 64'h0020_0000);
    issue(6'b101010, 5'h02, 16'h0, 64'h200, 64'h10, 64'hDEAD_BEEF_1234_5678);
    mem(1'b1, 1'b0, 64'h210, 64'h1234_5678);
  endtask

  task automatic s_illegal();
    issue(6'b010100, 5'h00, 16'h0, 64'h0, 64'h0, 64'h0);
    chk({o_ill, o_req}, 2'b10);
    issue(6'b000001, 5'h04, 16'h0, 64'h0, 64'h0, 64'h0);
    chk({o_ill, o_req}, 2'b10);
    issue(6'b000010, 5'h04, 16'h0, 64'h0, 64'h0, 64'h0);
    chk({o_ill, o_req}, 2'b10);
    apb(1'b0, fls_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, fls_pkg::ADDR_ILL_CNT, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, fls_pkg::ADDR_STATUS, 32'h0000_0002);
    apb(1'b0, fls_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, fls_pkg::ADDR_EA_LO, 32'h0);
    chk(rd, 32'h0000_0210);
    apb(1'b0, fls_pkg::ADDR_EA_HI, 32'h0);
    chk(rd, 32'h0000_0000);
  endtask

  // Reset in mid-run drops readiness and clears the invalid-form count
  task automatic s_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({o_rdy, o_ill, o_req, o_fwe, o_gwe}, 5'b0_0000);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(o_rdy, 1'b1);
    apb(1'b0, fls_pkg::ADDR_ILL_CNT, 32'h0);
    chk(rd, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    {rst_n, v, st, dbl, idx, upd, iw, cr, psel, pen, pwr} = 11'h0;
    {bfld, fpr, disp, paddr, pwdata, mwait} = 70'h0;
    {bv, iv, fv, mdata} = 256'h0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_loads();
    s_stores();
    s_illegal();
    s_reset();
    finish_test();
  end
endmodule

bind fls_top fls_top_sva u_sva (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_ISSUE_VALID(I_ISSUE_VALID), .O_ISSUE_READY(O_ISSUE_READY), .I_IS_STORE(I_IS_STORE),
  .I_IS_INDEXED(I_IS_INDEXED), .I_IS_UPDATE(I_IS_UPDATE), .I_IS_INT_WORD(I_IS_INT_WORD),
  .I_COND_RECORD_BIT(I_COND_RECORD_BIT), .I_BASE_REG_FIELD(I_BASE_REG_FIELD),
  .I_DISPLACEMENT(I_DISPLACEMENT), .I_BASE_VAL(I_BASE_VAL), .I_INDEX_VAL(I_INDEX_VAL),
  .O_ILLEGAL(O_ILLEGAL), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
  .O_MEM_DWORD(O_MEM_DWORD), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
  .I_MEM_ACK(I_MEM_ACK), .I_MEM_RDATA(I_MEM_RDATA), .O_FPR_WE(O_FPR_WE),
  .O_FPR_WDATA(O_FPR_WDATA), .O_GPR_WE(O_GPR_WE), .O_GPR_WDATA(O_GPR_WDATA));

`default_nettype wire
